// *** hdl/plld_pkg.sv ***
// Package: register map, field positions, reset values and types of the lock-detect block
//
// Notes on behaviour
// - Integer feedback mode means modulator order code zero; codes one-three are orders.
// - Hold resistor code bits 6:4, capacitor code bits 2:0; drive both to filter.
// - Raw-lock routing bit sends undebounced selected lock to the status pin.
// - Precision enable bit selects the window comparator detector for lock.
// - Debounce code 0 none; 1, 2, 3 give 570, 5700, 57000 cycles.
// - Sticky select zero follows lock live; one holds lock once asserted.
// - Calibration-bypass zero enables detection after calibration; one also during it.
// - Detector disable bit turns detection off and forces lock asserted.
// - Drive three-bit code selecting the lock-detect RC filter resistor.
// - Drive four-bit high-threshold code to the comparator, reset code 0x8.
// - Drive four-bit low-threshold code to the comparator, reset code 0x8.
// - Calibration-done flag reads zero while running, one once complete.
// - Calibration-fail flag, valid while done is one: zero success, one failure.
// - Six-bit read-only calibration band, meaningful once calibration is done.
package plld_pkg;

	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [7:0] ADDR_TPOLE = 8'h00;
	localparam logic [7:0] ADDR_LKCFG = 8'h04;
	localparam logic [7:0] ADDR_THRSH = 8'h08;
	localparam logic [7:0] ADDR_CALST = 8'h0c;
	localparam logic [7:0] ADDR_IRQST = 8'h10;
	localparam logic [7:0] ADDR_IRQMK = 8'h14;

	// ****************************************
	// Reset values and writable masks
	// ****************************************
	localparam logic [7:0] TPOLE_RST = 8'h37;
	localparam logic [7:0] TPOLE_WMASK = 8'hf7;
	localparam logic [15:0] LKCFG_RST = 16'h0180;
	localparam logic [15:0] LKCFG_WMASK = 16'h03ff;
	localparam logic [7:0] THRSH_RST = 8'h88;
	localparam logic [3:0] IRQ_RST = 4'h0;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int TP_BYP = 7;
	localparam int LK_RAW = 9;
	localparam int LK_PREC = 8;
	localparam int LK_TMR = 6;
	localparam int LK_STICKY = 5;
	localparam int LK_CALBYP = 4;
	localparam int LK_DIS = 3;
	localparam int CS_FAIL = 7;
	localparam int CS_DONE = 6;

	// Interrupt bit positions
	localparam int EV_LOCK = 0;
	localparam int EV_LOL = 1;
	localparam int EV_CDONE = 2;
	localparam int EV_CFAIL = 3;

	// ****************************************
	// Debounce counts in system clock cycles
	// ****************************************
	localparam int DEB_CNT1 = 570;
	localparam int DEB_CNT2 = 5700;
	localparam int DEB_CNT3 = 57000;
	localparam int DEB_W = 17;

	// Debounce state
	typedef enum logic [1:0] {
		DEB_IDLE = 2'b00,
		DEB_COUNT = 2'b01,
		DEB_LOCKED = 2'b10
	} plld_deb_t;

	// APB request and answer
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} plld_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} plld_apb_rsp_t;

	// Analog loop inputs
	typedef struct packed {
		logic orig_lock;
		logic prec_lock;
		logic cal_done;
		logic cal_fail;
		logic [5:0] cal_band;
		logic [1:0] fb_mod_order;
	} plld_ana_in_t;

	// Analog loop controls
	typedef struct packed {
		logic third_pole_bypass;
		logic [2:0] third_pole_resistor_code;
		logic [2:0] third_pole_capacitor_code;
		logic [2:0] lock_rc_code;
		logic [3:0] window_high_threshold;
		logic [3:0] window_low_threshold;
		logic prec_en;
	} plld_ana_out_t;

endpackage

// *** hdl/plld_top.sv ***
// Lock-detect and calibration-status register block with APB slave
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module plld_top #(
	parameter int DEB_CNT1 = plld_pkg::DEB_CNT1,
	parameter int DEB_CNT2 = plld_pkg::DEB_CNT2,
	parameter int DEB_CNT3 = plld_pkg::DEB_CNT3
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire plld_pkg::plld_apb_req_t i_apb,
	output plld_pkg::plld_apb_rsp_t o_apb,
	input wire plld_pkg::plld_ana_in_t i_ana,
	output plld_pkg::plld_ana_out_t o_ana,
	output logic o_lock,
	output logic o_serial_out_status_pin,
	output logic o_irq
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] tpole;
		logic [15:0] lkcfg;
		logic [7:0] thrsh;
		logic [3:0] irq_sts;
		logic [3:0] irq_msk;
		plld_pkg::plld_deb_t deb;
		logic [plld_pkg::DEB_W-1:0] cnt;
		logic sticky;
		logic lock;
		logic pin;
		logic done_prev;
		logic [31:0] rdata;
	} plld_state_t;

	plld_state_t st_r;
	plld_state_t st_nxt;
	logic raw_sel;
	logic detect_en;
	logic raw_q;
	logic deb_lock;
	logic lock_now;
	logic [plld_pkg::DEB_W-1:0] limit;
	logic [plld_pkg::DEB_W-1:0] cnt_inc;
	logic [1:0] tmr;
	logic wr_en;
	logic setup;
	logic mapped;
	logic [3:0] ev;

	// ****************************************
	// Lock path
	// ****************************************
	// Detector select, enable window and debounce limit
	always_comb
	begin
		raw_sel = st_r.lkcfg[plld_pkg::LK_PREC] ? i_ana.prec_lock : i_ana.orig_lock;
		detect_en = st_r.lkcfg[plld_pkg::LK_CALBYP] | i_ana.cal_done;
		raw_q = raw_sel & detect_en;
		tmr = st_r.lkcfg[plld_pkg::LK_TMR +: 2];
		case (tmr)
			2'h1: limit = plld_pkg::DEB_W'(DEB_CNT1);
			2'h2: limit = plld_pkg::DEB_W'(DEB_CNT2);
			2'h3: limit = plld_pkg::DEB_W'(DEB_CNT3);
			default: limit = '0;
		endcase
		cnt_inc = st_r.cnt + plld_pkg::DEB_W'(1);
		deb_lock = (tmr == 2'h0) ? raw_q : (st_r.deb == plld_pkg::DEB_LOCKED);
		if (st_r.lkcfg[plld_pkg::LK_DIS])
		begin
			lock_now = 1'b1;
		end
		else if (st_r.lkcfg[plld_pkg::LK_STICKY])
		begin
			lock_now = st_r.sticky | deb_lock;
		end
		else
		begin
			lock_now = deb_lock;
		end
	end

	// APB decode helpers
	always_comb
	begin
		setup = i_apb.psel & ~i_apb.penable;
		wr_en = i_apb.psel & i_apb.penable & i_apb.pwrite;
		if (i_apb.paddr == plld_pkg::ADDR_TPOLE)
			mapped = 1'b1;
		else if (i_apb.paddr == plld_pkg::ADDR_LKCFG)
			mapped = 1'b1;
		else if (i_apb.paddr == plld_pkg::ADDR_THRSH)
			mapped = 1'b1;
		else if (i_apb.paddr == plld_pkg::ADDR_CALST)
			mapped = 1'b1;
		else if (i_apb.paddr == plld_pkg::ADDR_IRQST)
			mapped = 1'b1;
		else if (i_apb.paddr == plld_pkg::ADDR_IRQMK)
			mapped = 1'b1;
		else
			mapped = 1'b0;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		st_nxt = st_r;
		ev = 4'h0;
		// Debounce counter, any raw drop restarts it
		case (st_r.deb)
			plld_pkg::DEB_IDLE:
			begin
				if (raw_q && limit <= plld_pkg::DEB_W'(1))
				begin
					st_nxt.deb = plld_pkg::DEB_LOCKED;
					st_nxt.cnt = plld_pkg::DEB_W'(1);
				end
				else if (raw_q)
				begin
					st_nxt.deb = plld_pkg::DEB_COUNT;
					st_nxt.cnt = plld_pkg::DEB_W'(1);
				end
			end
			plld_pkg::DEB_COUNT:
			begin
				if (!raw_q)
				begin
					st_nxt.deb = plld_pkg::DEB_IDLE;
					st_nxt.cnt = '0;
				end
				else if (cnt_inc >= limit)
				begin
					st_nxt.deb = plld_pkg::DEB_LOCKED;
				end
				else
				begin
					st_nxt.cnt = cnt_inc;
				end
			end
			default:
			begin
				if (!raw_q)
				begin
					st_nxt.deb = plld_pkg::DEB_IDLE;
					st_nxt.cnt = '0;
				end
			end
		endcase
		// Sticky hold, released when the select bit drops
		st_nxt.sticky = st_r.lkcfg[plld_pkg::LK_STICKY] & (st_r.sticky | deb_lock);
		st_nxt.lock = lock_now;
		st_nxt.pin = st_r.lkcfg[plld_pkg::LK_RAW] ? raw_sel : lock_now;
		st_nxt.done_prev = i_ana.cal_done;
		// Events
		ev[plld_pkg::EV_LOCK] = lock_now & ~st_r.lock;
		ev[plld_pkg::EV_LOL] = ~lock_now & st_r.lock;
		ev[plld_pkg::EV_CDONE] = i_ana.cal_done & ~st_r.done_prev;
		ev[plld_pkg::EV_CFAIL] = i_ana.cal_done & ~st_r.done_prev & i_ana.cal_fail;
		// Register writes, reserved bits kept at zero
		if (wr_en && i_apb.paddr == plld_pkg::ADDR_TPOLE)
		begin
			st_nxt.tpole = i_apb.pwdata[7:0] & plld_pkg::TPOLE_WMASK;
		end
		else if (wr_en && i_apb.paddr == plld_pkg::ADDR_LKCFG)
		begin
			st_nxt.lkcfg = i_apb.pwdata[15:0] & plld_pkg::LKCFG_WMASK;
		end
		else if (wr_en && i_apb.paddr == plld_pkg::ADDR_THRSH)
		begin
			st_nxt.thrsh = i_apb.pwdata[7:0];
		end
		else if (wr_en && i_apb.paddr == plld_pkg::ADDR_IRQMK)
		begin
			st_nxt.irq_msk = i_apb.pwdata[3:0];
		end
		// Sticky status: write one clears, a new event wins
		if (wr_en && i_apb.paddr == plld_pkg::ADDR_IRQST)
		begin
			st_nxt.irq_sts = (st_r.irq_sts & ~i_apb.pwdata[3:0]) | ev;
		end
		else
		begin
			st_nxt.irq_sts = st_r.irq_sts | ev;
		end
		// Read data captured in the setup cycle
		if (setup && i_apb.paddr == plld_pkg::ADDR_TPOLE)
		begin
			st_nxt.rdata = {24'h000000, st_r.tpole};
		end
		else if (setup && i_apb.paddr == plld_pkg::ADDR_LKCFG)
		begin
			st_nxt.rdata = {16'h0000, st_r.lkcfg};
		end
		else if (setup && i_apb.paddr == plld_pkg::ADDR_THRSH)
		begin
			st_nxt.rdata = {24'h000000, st_r.thrsh};
		end
		else if (setup && i_apb.paddr == plld_pkg::ADDR_CALST)
		begin
			// Fail and band read zero until calibration is done
			st_nxt.rdata = {24'h000000, i_ana.cal_fail & i_ana.cal_done, i_ana.cal_done,
				i_ana.cal_band & {6{i_ana.cal_done}}};
		end
		else if (setup && i_apb.paddr == plld_pkg::ADDR_IRQST)
		begin
			st_nxt.rdata = {28'h0000000, st_r.irq_sts};
		end
		else if (setup && i_apb.paddr == plld_pkg::ADDR_IRQMK)
		begin
			st_nxt.rdata = {28'h0000000, st_r.irq_msk};
		end
		else if (setup)
		begin
			st_nxt.rdata = 32'h00000000;
		end
	end

	// State register
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st_r.tpole <= plld_pkg::TPOLE_RST;
			st_r.lkcfg <= plld_pkg::LKCFG_RST;
			st_r.thrsh <= plld_pkg::THRSH_RST;
			st_r.irq_sts <= plld_pkg::IRQ_RST;
			st_r.irq_msk <= plld_pkg::IRQ_RST;
			st_r.deb <= plld_pkg::DEB_IDLE;
			st_r.cnt <= '0;
			st_r.sticky <= 1'b0;
			st_r.lock <= 1'b0;
			st_r.pin <= 1'b0;
			st_r.done_prev <= 1'b0;
			st_r.rdata <= 32'h00000000;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Analog controls from the registers, bypass also gated by the feedback mode
	always_comb
	begin
		// Bypass passed on only in integer feedback mode
		o_ana.third_pole_bypass = st_r.tpole[plld_pkg::TP_BYP]
			& (i_ana.fb_mod_order == 2'h0);
		o_ana.third_pole_resistor_code = st_r.tpole[6:4];
		o_ana.third_pole_capacitor_code = st_r.tpole[2:0];
		o_ana.lock_rc_code = st_r.lkcfg[2:0];
		o_ana.window_high_threshold = st_r.thrsh[7:4];
		o_ana.window_low_threshold = st_r.thrsh[3:0];
		o_ana.prec_en = st_r.lkcfg[plld_pkg::LK_PREC];
		o_apb.pready = 1'b1;
		o_apb.pslverr = i_apb.psel & i_apb.penable & ~mapped;
		o_apb.prdata = st_r.rdata;
		o_lock = st_r.lock;
		o_serial_out_status_pin = st_r.pin;
		o_irq = |(st_r.irq_sts & st_r.irq_msk);
	end

	// ****************************************
	// Checks
	// ****************************************
	// Consecutive raw-lock cycle count for debounce checks
	logic [plld_pkg::DEB_W-1:0] hi_run_r;
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			hi_run_r <= '0;
		else if (!raw_q)
			hi_run_r <= '0;
		else if (hi_run_r != '1)
			hi_run_r <= hi_run_r + plld_pkg::DEB_W'(1);
	end

	property p_bypass_gate;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		o_ana.third_pole_bypass |-> (i_ana.fb_mod_order == 2'h0);
	endproperty
	a_bypass_gate: assert property (p_bypass_gate)
		else $error("bypass outside integer mode");

	property p_force_lock;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		st_r.lkcfg[plld_pkg::LK_DIS] |=> o_lock;
	endproperty
	a_force_lock: assert property (p_force_lock)
		else $error("disabled detector not forcing lock");

	property p_cal_gate;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		$rose(st_r.deb == plld_pkg::DEB_COUNT) |-> $past(detect_en);
	endproperty
	a_cal_gate: assert property (p_cal_gate)
		else $error("count began with detection off");

	property p_deb_full;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		$rose(st_r.deb == plld_pkg::DEB_LOCKED) && $stable(tmr) |-> hi_run_r >= limit;
	endproperty
	a_deb_full: assert property (p_deb_full) else $error("debounce ended early");

	property p_deb_drop;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		!raw_q |=> st_r.deb == plld_pkg::DEB_IDLE && st_r.cnt == '0;
	endproperty
	a_deb_drop: assert property (p_deb_drop)
		else $error("raw drop did not restart count");

	property p_sticky_hold;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		o_lock && st_r.lkcfg[plld_pkg::LK_STICKY] ##1 st_r.lkcfg[plld_pkg::LK_STICKY] |=> o_lock;
	endproperty
	a_sticky_hold: assert property (p_sticky_hold) else $error("sticky lock dropped");

	property p_realtime;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		tmr == 2'h0 && !st_r.lkcfg[plld_pkg::LK_STICKY] && !st_r.lkcfg[plld_pkg::LK_DIS]
			|=> o_lock == $past(raw_q);
	endproperty
	a_realtime: assert property (p_realtime)
		else $error("live lock not following detector");

	property p_raw_pin;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		st_r.lkcfg[plld_pkg::LK_RAW] |=> o_serial_out_status_pin == $past(raw_sel);
	endproperty
	a_raw_pin: assert property (p_raw_pin) else $error("status pin not raw lock");

	property p_lol_event;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		$fell(o_lock) |-> st_r.irq_sts[plld_pkg::EV_LOL];
	endproperty
	a_lol_event: assert property (p_lol_event) else $error("loss of lock not flagged");

	property p_cal_read_gate;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		setup && i_apb.paddr == plld_pkg::ADDR_CALST && !i_ana.cal_done
			|=> o_apb.prdata[7:0] == 8'h00;
	endproperty
	a_cal_read_gate: assert property (p_cal_read_gate)
		else $error("calibration result shown before done");

	property p_pole_codes;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		wr_en && i_apb.paddr == plld_pkg::ADDR_TPOLE
			|=> o_ana.third_pole_resistor_code == $past(i_apb.pwdata[6:4])
			&& o_ana.third_pole_capacitor_code == $past(i_apb.pwdata[2:0]);
	endproperty
	a_pole_codes: assert property (p_pole_codes)
		else $error("pole codes not driven as written");

	property p_thresholds;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		wr_en && i_apb.paddr == plld_pkg::ADDR_THRSH
			|=> {o_ana.window_high_threshold, o_ana.window_low_threshold}
			== $past(i_apb.pwdata[7:0]);
	endproperty
	a_thresholds: assert property (p_thresholds)
		else $error("threshold codes not driven as written");

	property p_reserved_zero;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		st_r.tpole[3] == 1'b0 && st_r.lkcfg[15:10] == 6'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bit held a one");

	property p_done_event;
		@(posedge i_ref_clk) disable iff (!i_nrst)
		$rose(i_ana.cal_done) |=> st_r.irq_sts[plld_pkg::EV_CDONE];
	endproperty
	a_done_event: assert property (p_done_event) else $error("calibration done not flagged");

	c_debounced: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
		$rose(st_r.deb == plld_pkg::DEB_LOCKED) && tmr == 2'h1);
	c_restart: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
		st_r.deb == plld_pkg::DEB_COUNT ##1 st_r.deb == plld_pkg::DEB_IDLE);
	c_sticky: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
		o_lock && st_r.sticky && !raw_q);
	c_cal_fail: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
		$rose(st_r.irq_sts[plld_pkg::EV_CFAIL]));
	c_irq: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) $rose(o_irq));

endmodule
`default_nettype wire

// *** bench/plld_ana_model.sv ***
// Behavioural analog loop: calibrator and raw lock comparators
`timescale 1ns/1ns
`default_nettype none
module plld_ana_model #(
	parameter int CAL_CYC = 30
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_recal,
	input wire logic i_fail,
	input wire logic [5:0] i_band,
	input wire logic i_orig,
	input wire logic i_prec,
	input wire logic [1:0] i_order,
	output plld_pkg::plld_ana_in_t o_ana
);
	int cnt;
	logic done;
	// Calibration runs after reset or on request
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			cnt <= 0;
		else if (i_recal)
			cnt <= 0;
		else if (cnt < CAL_CYC)
			cnt <= cnt + 1;
	end
	assign done = (cnt >= CAL_CYC);
	// Fail and band are junk until done, so a missing gate shows
	assign o_ana = {i_orig, i_prec, done, done ? i_fail : ~i_fail, done ? i_band : ~i_band, i_order};
endmodule
`default_nettype wire

// *** bench/pll_lock_detect_control_bench.sv ***
// Self-checking bench of the lock-detect register block
`timescale 1ns/1ns
`default_nettype none
module pll_lock_detect_control_bench;
	localparam int D1 = 5;
	localparam int D2 = 7;
	localparam int D3 = 9;
	logic i_ref_clk = 1'b0;
	logic i_nrst = 1'b0;
	plld_pkg::plld_apb_req_t req = '0;
	plld_pkg::plld_apb_rsp_t rsp;
	plld_pkg::plld_ana_in_t ana;
	plld_pkg::plld_ana_out_t aout;
	logic lock;
	logic pin;
	logic irq;
	logic recal = 1'b0;
	logic fail = 1'b0;
	logic orig = 1'b0;
	logic prec = 1'b0;
	logic [1:0] order = 2'h3;
	logic [31:0] q;
	logic err;
	int bad_count = 0;
	int checks_done = 0;
	int n;
	int l0;
	int deb [4] = '{0, D1, D2, D3};

	// Clock
	always #2 i_ref_clk = ~i_ref_clk;

	plld_top #(.DEB_CNT1(D1), .DEB_CNT2(D2), .DEB_CNT3(D3)) i_dut (
		.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_apb(req), .o_apb(rsp), .i_ana(ana),
		.o_ana(aout), .o_lock(lock), .o_serial_out_status_pin(pin), .o_irq(irq));

	plld_ana_model i_ana (
		.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_recal(recal), .i_fail(fail),
		.i_band(6'h2a), .i_orig(orig), .i_prec(prec), .i_order(order), .o_ana(ana));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge i_ref_clk);
	endtask

	// APB transfer: setup, access until pready, then release
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge i_ref_clk);
		req.penable <= 1'b1;
		do @(posedge i_ref_clk); while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	// Raise precision raw lock, count edges until lock shows
	task automatic lat(output int k);
		prec <= 1'b1;
		k = 0;
		do
		begin
			@(posedge i_ref_clk);
			k++;
		end
		while (lock !== 1'b1 && k < 200);
	endtask

	// Watchdog
	initial
	begin
		tick(5000);
		bad_count++;
		finish_test();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		tick(20);
		i_nrst <= 1'b1;
		rd(plld_pkg::ADDR_CALST, 32'h0);
		chk(32'(q[plld_pkg::CS_DONE]), 32'h0);
		rd(plld_pkg::ADDR_TPOLE, 32'h37);
		rd(plld_pkg::ADDR_LKCFG, 32'h180);
		rd(plld_pkg::ADDR_THRSH, 32'h88);
		rd(plld_pkg::ADDR_IRQMK, 32'h0);
		chk(32'(aout), 32'h1f111);
		tick(30);
		rd(plld_pkg::ADDR_CALST, 32'h6a);
		// Third pole codes; bypass only in integer mode
		order <= 2'h0;
		apb(1'b1, plld_pkg::ADDR_TPOLE, 32'hff);
		rd(plld_pkg::ADDR_TPOLE, 32'hf7);
		chk(32'(aout[18:12]), 32'h7f);
		order <= 2'h1;
		@(posedge i_ref_clk);
		chk(32'(aout.third_pole_bypass), 32'h0);
		apb(1'b1, plld_pkg::ADDR_THRSH, 32'ha5);
		rd(plld_pkg::ADDR_THRSH, 32'ha5);
		chk(32'(aout[8:1]), 32'ha5);
		apb(1'b1, plld_pkg::ADDR_LKCFG, 32'hffff);
		rd(plld_pkg::ADDR_LKCFG, 32'h3ff);
		chk(32'(aout.lock_rc_code), 32'h7);
		chk(32'(lock), 32'h1);
		// Debounce length per timer code
		for (int t = 0; t < 4; t++)
		begin
			apb(1'b1, plld_pkg::ADDR_LKCFG, 32'h100 | 32'(t << 6));
			tick(4);
			lat(n);
			if (t == 0)
				l0 = n;
			else
				chk(32'(n - l0), 32'(deb[t]));
			prec <= 1'b0;
			tick(12);
			chk(32'(lock), 32'h0);
		end
		// Short raw pulse restarts the count
		apb(1'b1, plld_pkg::ADDR_LKCFG, 32'h140);
		prec <= 1'b1;
		tick(3);
		prec <= 1'b0;
		@(posedge i_ref_clk);
		lat(n);
		chk(32'(n - l0), 32'(D1));
		prec <= 1'b0;
		// Sticky lock holds after raw drop
		apb(1'b1, plld_pkg::ADDR_LKCFG, 32'h120);
		lat(n);
		prec <= 1'b0;
		tick(6);
		chk(32'(lock), 32'h1);
		apb(1'b1, plld_pkg::ADDR_LKCFG, 32'h100);
		tick(4);
		chk(32'(lock), 32'h0);
		// Detection gated by calibration unless bypassed
		fail <= 1'b1;
		recal <= 1'b1;
		@(posedge i_ref_clk);
		recal <= 1'b0;
		prec <= 1'b1;
		tick(5);
		chk(32'(lock), 32'h0);
		apb(1'b1, plld_pkg::ADDR_LKCFG, 32'h110);
		tick(4);
		chk(32'(lock), 32'h1);
		prec <= 1'b0;
		tick(30);
		rd(plld_pkg::ADDR_CALST, 32'hea);
		apb(1'b1, plld_pkg::ADDR_CALST, 32'h0);
		rd(plld_pkg::ADDR_CALST, 32'hea);
		// Raw lock to the status pin, detector select
		apb(1'b1, plld_pkg::ADDR_LKCFG, 32'h3c0);
		orig <= 1'b1;
		tick(3);
		chk(32'(pin), 32'h0);
		prec <= 1'b1;
		tick(3);
		chk(32'({pin, lock}), 32'h2);
		apb(1'b1, plld_pkg::ADDR_LKCFG, 32'h2c0);
		prec <= 1'b0;
		tick(3);
		chk(32'(pin), 32'h1);
		orig <= 1'b0;
		tick(3);
		chk(32'(pin), 32'h0);
		// Interrupt status, mask and clear
		apb(1'b1, plld_pkg::ADDR_IRQMK, 32'hf);
		rd(plld_pkg::ADDR_IRQST, 32'hf);
		chk(32'(irq), 32'h1);
		apb(1'b1, plld_pkg::ADDR_IRQMK, 32'h0);
		@(posedge i_ref_clk);
		chk(32'(irq), 32'h0);
		apb(1'b1, plld_pkg::ADDR_IRQST, 32'hf);
		rd(plld_pkg::ADDR_IRQST, 32'h0);
		// Unmapped address
		apb(1'b0, 8'h20, 32'h0);
		chk({q[30:0], err}, 32'h1);
		finish_test();
	end
endmodule
`default_nettype wire
